// ---- design/exec_pkg.sv ----
package exec_pkg;

  // ----------------------------------------------------------------
  // Widths and data pointer layout
  // ----------------------------------------------------------------
  localparam int NIB_W = 4;
  localparam int DP_ADDR_W = 10;
  localparam int DP_BANK_LSB = 8;
  localparam int DP_FILE_LSB = 4;

  // ----------------------------------------------------------------
  // Values after reset and fixed nibbles
  // ----------------------------------------------------------------
  localparam logic [3:0] NIB_RST = 4'h0;
  localparam logic [7:0] WIDE_RST = 8'h00;
  localparam logic [2:0] PAGE_RST = 3'h0;
  localparam logic [1:0] BANK_RST = 2'h0;
  localparam logic [3:0] ROW_WRAP_LOW = 4'h0;
  localparam logic [3:0] ROW_WRAP_HIGH = 4'hf;
  localparam logic [3:0] ROW_STEP = 4'h1;

  // ----------------------------------------------------------------
  // Decoded operations and sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    op_nop, op_b_to_acc, op_acc_to_b, op_row_to_acc, op_acc_to_row,
    op_pack_wide_reg, op_unpack_wide_reg, op_acc_to_page_reg,
    op_page_reg_to_acc, op_bank_to_acc, op_file_to_acc,
    op_stackptr_to_acc, op_load_file_row_imm, op_load_bank_imm,
    op_increment_row_skip, op_decrement_row_skip, op_load_acc_from_ram,
    op_swap_acc_ram, op_swap_acc_ram_dec, op_swap_acc_ram_inc,
    op_store_acc_to_ram
  } op_t;

  typedef enum logic [1:0] {
    st_fetch = 2'b01,
    st_exec = 2'b10
  } state_t;

endpackage

// ---- design/nibble_ram.sv ----
`timescale 1ns/100ps
module nibble_ram #(
  parameter int ADDR_W = exec_pkg::DP_ADDR_W,
  parameter int DATA_W = exec_pkg::NIB_W
) (
  // Clock
  input wire logic clk,
  // Single shared address
  input wire logic [ADDR_W-1:0] addr,
  // Write side
  input wire logic we,
  input wire logic [DATA_W-1:0] wdata,
  // Registered read data, valid one edge after addr
  output logic [DATA_W-1:0] rdata_q
);

  logic [DATA_W-1:0] mem [2**ADDR_W];

  // No reset: contents are undefined until software writes them
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata_q <= mem[addr];
  end

endmodule

// ---- design/nibble_transfer_ram_exec.sv ----
// Functional notes
// - Register-transfer copies B into A.
// - Reverse transfer copies A into B.
// - Copy Y into A.
// - Copy A into Y.
// - Pack: B into upper nibble of E, A into lower nibble.
// - Unpack: E upper nibble into B, lower nibble into A.
// - Load three-bit D from A bits two to zero.
// - Load A bits two to zero from D.
// - Load A bits one and zero from two-bit Z.
// - Copy X into A.
// - Load A bits two to zero from the stack pointer.
// - Paired immediate load writes first field to X, second to Y.
// - In a run of paired X/Y loads only the first executes.
// - Bank load writes the two-bit immediate into Z.
// - Increment Y modulo sixteen; skip next instruction when it becomes zero.
// - Decrement Y modulo sixteen; skip next instruction when it becomes 15.
// - Load A from pointed RAM nibble, then X ^= immediate.
// - Swap A with pointed RAM nibble, then X ^= immediate.
// - Swap, X update, decrement Y; skip next when Y becomes 15.
// - Swap, X update, increment Y; skip next when Y becomes zero.
// - Store A to pointed RAM nibble, then X ^= immediate.
`timescale 1ns/100ps
module nibble_transfer_ram_exec (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Decoded instruction: hi is x, lo is y, z or j
  input wire logic instr_valid,
  input wire exec_pkg::op_t instr_op,
  input wire logic [3:0] instr_imm_hi,
  input wire logic [3:0] instr_imm_lo,
  // Stack pointer of the call logic
  input wire logic [2:0] stack_pointer,
  // Sequencing
  output logic instr_ready,
  output logic retire,
  output logic skipped,
  // Architectural registers
  output logic [3:0] acc,
  output logic [3:0] reg_b,
  output logic [3:0] file_x,
  output logic [3:0] row_y,
  output logic [7:0] wide_e,
  output logic [2:0] page_d,
  output logic [1:0] bank_z
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Returns {skip, new row}; skip on wrap in the step direction
  function automatic logic [4:0] row_step(input logic [3:0] y,
                                          input logic up);
    logic [3:0] n;
    n = up ? y + exec_pkg::ROW_STEP : y - exec_pkg::ROW_STEP;
    row_step = {(up ? n == exec_pkg::ROW_WRAP_LOW
                    : n == exec_pkg::ROW_WRAP_HIGH), n};
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  exec_pkg::state_t state_q, state_d;
  exec_pkg::op_t op_q, op_d;
  logic [3:0] imm_hi_q, imm_hi_d, imm_lo_q, imm_lo_d;
  logic [3:0] acc_q, acc_d, b_q, b_d, x_q, x_d, y_q, y_d;
  logic [7:0] e_q, e_d;
  logic [2:0] d_q, d_d;
  logic [1:0] z_q, z_d;
  logic skip_q, skip_d, squash_q, squash_d, last_lxy_q, last_lxy_d;
  logic ready_q, ready_d, retire_q, retire_d, skipped_q, skipped_d;
  logic [4:0] step;
  logic run;
  logic ram_we;
  logic [exec_pkg::NIB_W-1:0] ram_rdata;
  logic [exec_pkg::DP_ADDR_W-1:0] dp;

  assign run = (state_q == exec_pkg::st_exec) && !squash_q;
  assign dp = {z_q, x_q, y_q};

  // Read is issued while fetching, so the nibble is ready for execute;
  // X, Y and Z only change at the end of execute, so the address holds.
  nibble_ram #(
    .ADDR_W(exec_pkg::DP_ADDR_W),
    .DATA_W(exec_pkg::NIB_W)
  ) u_ram (
    .clk(clk),
    .addr(dp),
    .we(ram_we),
    .wdata(acc_q),
    .rdata_q(ram_rdata)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    op_d = op_q;
    imm_hi_d = imm_hi_q;
    imm_lo_d = imm_lo_q;
    acc_d = acc_q;
    b_d = b_q;
    x_d = x_q;
    y_d = y_q;
    e_d = e_q;
    d_d = d_q;
    z_d = z_q;
    skip_d = skip_q;
    squash_d = squash_q;
    last_lxy_d = last_lxy_q;
    retire_d = 1'b0;
    skipped_d = 1'b0;
    ram_we = 1'b0;
    step = 5'h00;
    unique case (state_q)
      exec_pkg::st_fetch: begin
        if (instr_valid) begin
          state_d = exec_pkg::st_exec;
          op_d = instr_op;
          imm_hi_d = instr_imm_hi;
          imm_lo_d = instr_imm_lo;
          // A pending skip or a repeated paired load is discarded
          squash_d = skip_q ||
                     (last_lxy_q &&
                      instr_op == exec_pkg::op_load_file_row_imm);
          last_lxy_d = instr_op == exec_pkg::op_load_file_row_imm;
          skip_d = 1'b0;
        end
      end
      exec_pkg::st_exec: begin
        state_d = exec_pkg::st_fetch;
        retire_d = !squash_q;
        skipped_d = squash_q;
        if (!squash_q) begin
          unique case (op_q)
            exec_pkg::op_b_to_acc: acc_d = b_q;
            exec_pkg::op_acc_to_b: b_d = acc_q;
            exec_pkg::op_row_to_acc: acc_d = y_q;
            exec_pkg::op_acc_to_row: y_d = acc_q;
            exec_pkg::op_pack_wide_reg: e_d = {b_q, acc_q};
            exec_pkg::op_unpack_wide_reg: begin
              b_d = e_q[7:4];
              acc_d = e_q[3:0];
            end
            exec_pkg::op_acc_to_page_reg: d_d = acc_q[2:0];
            // Upper bits of A are cleared on partial loads
            exec_pkg::op_page_reg_to_acc: acc_d = {1'b0, d_q};
            exec_pkg::op_bank_to_acc: acc_d = {2'b00, z_q};
            exec_pkg::op_file_to_acc: acc_d = x_q;
            exec_pkg::op_stackptr_to_acc: begin
              acc_d = {1'b0, stack_pointer};
            end
            exec_pkg::op_load_file_row_imm: begin
              x_d = imm_hi_q;
              y_d = imm_lo_q;
            end
            exec_pkg::op_load_bank_imm: z_d = imm_lo_q[1:0];
            exec_pkg::op_increment_row_skip: begin
              step = row_step(y_q, 1'b1);
              {skip_d, y_d} = step;
            end
            exec_pkg::op_decrement_row_skip: begin
              step = row_step(y_q, 1'b0);
              {skip_d, y_d} = step;
            end
            exec_pkg::op_load_acc_from_ram: begin
              acc_d = ram_rdata;
              x_d = x_q ^ imm_lo_q;
            end
            exec_pkg::op_swap_acc_ram: begin
              ram_we = 1'b1;
              acc_d = ram_rdata;
              x_d = x_q ^ imm_lo_q;
            end
            exec_pkg::op_swap_acc_ram_dec: begin
              ram_we = 1'b1;
              acc_d = ram_rdata;
              x_d = x_q ^ imm_lo_q;
              step = row_step(y_q, 1'b0);
              {skip_d, y_d} = step;
            end
            exec_pkg::op_swap_acc_ram_inc: begin
              ram_we = 1'b1;
              acc_d = ram_rdata;
              x_d = x_q ^ imm_lo_q;
              step = row_step(y_q, 1'b1);
              {skip_d, y_d} = step;
            end
            exec_pkg::op_store_acc_to_ram: begin
              ram_we = 1'b1;
              x_d = x_q ^ imm_lo_q;
            end
            default: begin
            end
          endcase
        end
      end
      default: state_d = exec_pkg::st_fetch;
    endcase
    ready_d = state_d == exec_pkg::st_fetch;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= exec_pkg::st_fetch;
      op_q <= exec_pkg::op_nop;
      imm_hi_q <= exec_pkg::NIB_RST;
      imm_lo_q <= exec_pkg::NIB_RST;
      acc_q <= exec_pkg::NIB_RST;
      b_q <= exec_pkg::NIB_RST;
      x_q <= exec_pkg::NIB_RST;
      y_q <= exec_pkg::NIB_RST;
      e_q <= exec_pkg::WIDE_RST;
      d_q <= exec_pkg::PAGE_RST;
      z_q <= exec_pkg::BANK_RST;
      skip_q <= 1'b0;
      squash_q <= 1'b0;
      last_lxy_q <= 1'b0;
      ready_q <= 1'b1;
      retire_q <= 1'b0;
      skipped_q <= 1'b0;
    end else begin
      state_q <= state_d;
      op_q <= op_d;
      imm_hi_q <= imm_hi_d;
      imm_lo_q <= imm_lo_d;
      acc_q <= acc_d;
      b_q <= b_d;
      x_q <= x_d;
      y_q <= y_d;
      e_q <= e_d;
      d_q <= d_d;
      z_q <= z_d;
      skip_q <= skip_d;
      squash_q <= squash_d;
      last_lxy_q <= last_lxy_d;
      ready_q <= ready_d;
      retire_q <= retire_d;
      skipped_q <= skipped_d;
    end
  end

  assign instr_ready = ready_q;
  assign retire = retire_q;
  assign skipped = skipped_q;
  assign acc = acc_q;
  assign reg_b = b_q;
  assign file_x = x_q;
  assign row_y = y_q;
  assign wide_e = e_q;
  assign page_d = d_q;
  assign bank_z = z_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence take_op(exec_pkg::op_t o);
    state_q == exec_pkg::st_fetch && instr_valid && instr_op == o;
  endsequence
  sequence run_op(exec_pkg::op_t o);
    run && op_q == o;
  endsequence

  a_acc_from_b: assert property (
    run_op(exec_pkg::op_b_to_acc) |=> acc_q == $past(b_q))
    else $error("A not loaded from B");
  a_b_from_acc: assert property (
    run_op(exec_pkg::op_acc_to_b) |=> b_q == $past(acc_q))
    else $error("B not loaded from A");
  a_acc_from_row: assert property (
    run_op(exec_pkg::op_row_to_acc) |=> acc_q == $past(y_q))
    else $error("A not loaded from Y");
  a_row_from_acc: assert property (
    run_op(exec_pkg::op_acc_to_row) |=> y_q == $past(acc_q))
    else $error("Y not loaded from A");
  a_wide_pack: assert property (
    run_op(exec_pkg::op_pack_wide_reg) |=>
      e_q[7:4] == $past(b_q) && e_q[3:0] == $past(acc_q))
    else $error("E pack wrong");
  a_wide_unpack: assert property (
    run_op(exec_pkg::op_unpack_wide_reg) |=>
      b_q == $past(e_q[7:4]) && acc_q == $past(e_q[3:0]))
    else $error("E unpack wrong");
  a_page_load: assert property (
    run_op(exec_pkg::op_acc_to_page_reg) |=> d_q == $past(acc_q[2:0]))
    else $error("D not loaded from A");
  a_page_to_acc: assert property (
    run_op(exec_pkg::op_page_reg_to_acc) |=>
      acc_q == {1'b0, $past(d_q)})
    else $error("A not loaded from D");
  a_bank_to_acc: assert property (
    run_op(exec_pkg::op_bank_to_acc) |=> acc_q == {2'b00, $past(z_q)})
    else $error("A not loaded from Z");
  a_file_to_acc: assert property (
    run_op(exec_pkg::op_file_to_acc) |=> acc_q == $past(x_q))
    else $error("A not loaded from X");
  a_sp_to_acc: assert property (
    run_op(exec_pkg::op_stackptr_to_acc) |=>
      acc_q == {1'b0, $past(stack_pointer)})
    else $error("A not loaded from stack pointer");
  a_pair_load: assert property (
    run_op(exec_pkg::op_load_file_row_imm) |=>
      x_q == $past(imm_hi_q) && y_q == $past(imm_lo_q))
    else $error("Paired load wrong");
  // The bench offers one instruction every three edges, so a run is told
  // by the last taken op rather than by a fixed spacing between takes
  a_pair_run: assert property (
    take_op(exec_pkg::op_load_file_row_imm) && last_lxy_q |=>
      ##1 skipped_q && !retire_q)
    else $error("Repeated paired load not skipped");
  a_bank_load: assert property (
    run_op(exec_pkg::op_load_bank_imm) |=> z_q == $past(imm_lo_q[1:0]))
    else $error("Z not loaded");
  a_inc_skip: assert property (
    run_op(exec_pkg::op_increment_row_skip) |=>
      y_q == $past(y_q) + 4'h1 && skip_q == (y_q == 4'h0))
    else $error("Increment skip wrong");
  a_dec_skip: assert property (
    run_op(exec_pkg::op_decrement_row_skip) |=>
      y_q == $past(y_q) - 4'h1 && skip_q == (y_q == 4'hf))
    else $error("Decrement skip wrong");
  a_ram_load: assert property (
    run_op(exec_pkg::op_load_acc_from_ram) |=>
      acc_q == $past(ram_rdata) && x_q == ($past(x_q) ^ $past(imm_lo_q)))
    else $error("RAM load wrong");
  a_ram_swap: assert property (
    run_op(exec_pkg::op_swap_acc_ram) |-> ram_we ##1
      acc_q == $past(ram_rdata) && x_q == ($past(x_q) ^ $past(imm_lo_q)))
    else $error("Swap wrong");
  a_swap_dec: assert property (
    run_op(exec_pkg::op_swap_acc_ram_dec) |=>
      y_q == $past(y_q) - 4'h1 && skip_q == (y_q == 4'hf))
    else $error("Swap-decrement wrong");
  a_swap_inc: assert property (
    run_op(exec_pkg::op_swap_acc_ram_inc) |=>
      y_q == $past(y_q) + 4'h1 && skip_q == (y_q == 4'h0))
    else $error("Swap-increment wrong");
  a_ram_store: assert property (
    run_op(exec_pkg::op_store_acc_to_ram) |-> ram_we ##1
      acc_q == $past(acc_q) && x_q == ($past(x_q) ^ $past(imm_lo_q)))
    else $error("Store wrong");
  a_one_cycle: assert property (
    state_q == exec_pkg::st_fetch && instr_valid |=>
      !ready_q ##1 ready_q && (retire_q ^ skipped_q))
    else $error("Instruction not finished in one machine cycle");

endmodule

// ---- sim/tb_nibble_transfer_ram_exec.sv ----
`timescale 1ns/100ps
module tb_nibble_transfer_ram_exec;
  // --------------------------------------------------------------
  // Stimulus and observed signals
  // --------------------------------------------------------------
  logic clk;
  logic rst;
  logic instr_valid;
  exec_pkg::op_t instr_op;
  logic [3:0] instr_imm_hi;
  logic [3:0] instr_imm_lo;
  logic [2:0] stack_pointer;
  logic instr_ready;
  logic retire;
  logic skipped;
  logic [3:0] acc;
  logic [3:0] reg_b;
  logic [3:0] file_x;
  logic [3:0] row_y;
  logic [7:0] wide_e;
  logic [2:0] page_d;
  logic [1:0] bank_z;
  int error_cnt;
  int samples_checked;

  nibble_transfer_ram_exec dut (
    .clk(clk),
    .rst(rst),
    .instr_valid(instr_valid),
    .instr_op(instr_op),
    .instr_imm_hi(instr_imm_hi),
    .instr_imm_lo(instr_imm_lo),
    .stack_pointer(stack_pointer),
    .instr_ready(instr_ready),
    .retire(retire),
    .skipped(skipped),
    .acc(acc),
    .reg_b(reg_b),
    .file_x(file_x),
    .row_y(row_y),
    .wide_e(wide_e),
    .page_d(page_d),
    .bank_z(bank_z)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] exp,
                     input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask

  task automatic final_report;
    $display("checks %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // One instruction: offer, see it taken, judge the pulse two edges on
  task automatic run(input exec_pkg::op_t op, input logic [3:0] hi,
                     input logic [3:0] lo, input logic skp);
    int n;
    n = 0;
    @(posedge clk);
    instr_valid <= 1'b1;
    instr_op <= op;
    instr_imm_hi <= hi;
    instr_imm_lo <= lo;
    #1;
    while (instr_ready !== 1'b1) begin
      if (n == 20) begin
        error_cnt++;
        $display("unexpected ready: expected 1, seen %b", instr_ready);
        final_report();
      end
      @(posedge clk);
      #1;
      n++;
    end
    @(posedge clk);
    instr_valid <= 1'b0;
    #1;
    chk("ready", 8'h00, {7'h0, instr_ready});
    @(posedge clk);
    #1;
    chk("retire", {7'h0, ~skp}, {7'h0, retire});
    chk("skipped", {7'h0, skp}, {7'h0, skipped});
  endtask

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_reset;
    @(posedge clk);
    #1;
    chk("acc", 8'h00, {4'h0, acc});
    chk("e", 8'h00, wide_e);
    chk("ready", 8'h01, {7'h0, instr_ready});
    $display("test reset done");
  endtask

  task automatic t_xfer;
    run(exec_pkg::op_load_file_row_imm, 4'h5, 4'ha, 1'b0);
    chk("x", 8'h05, {4'h0, file_x});
    chk("y", 8'h0a, {4'h0, row_y});
    run(exec_pkg::op_file_to_acc, 4'h0, 4'h0, 1'b0);
    chk("acc", 8'h05, {4'h0, acc});
    run(exec_pkg::op_acc_to_b, 4'h0, 4'h0, 1'b0);
    chk("b", 8'h05, {4'h0, reg_b});
    run(exec_pkg::op_row_to_acc, 4'h0, 4'h0, 1'b0);
    chk("acc", 8'h0a, {4'h0, acc});
    run(exec_pkg::op_pack_wide_reg, 4'h0, 4'h0, 1'b0);
    chk("e", 8'h5a, wide_e);
    run(exec_pkg::op_acc_to_b, 4'h0, 4'h0, 1'b0);
    run(exec_pkg::op_file_to_acc, 4'h0, 4'h0, 1'b0);
    run(exec_pkg::op_unpack_wide_reg, 4'h0, 4'h0, 1'b0);
    chk("b", 8'h05, {4'h0, reg_b});
    chk("acc", 8'h0a, {4'h0, acc});
    run(exec_pkg::op_b_to_acc, 4'h0, 4'h0, 1'b0);
    chk("acc", 8'h05, {4'h0, acc});
    run(exec_pkg::op_acc_to_row, 4'h0, 4'h0, 1'b0);
    chk("y", 8'h05, {4'h0, row_y});
    $display("test transfers done");
  endtask

  // Starting from A all ones shows that upper bits are cleared
  task automatic t_part;
    run(exec_pkg::op_load_file_row_imm, 4'hf, 4'hf, 1'b0);
    run(exec_pkg::op_file_to_acc, 4'h0, 4'h0, 1'b0);
    run(exec_pkg::op_acc_to_page_reg, 4'h0, 4'h0, 1'b0);
    chk("d", 8'h07, {5'h0, page_d});
    run(exec_pkg::op_load_bank_imm, 4'h0, 4'h7, 1'b0);
    chk("z", 8'h03, {6'h0, bank_z});
    run(exec_pkg::op_page_reg_to_acc, 4'h0, 4'h0, 1'b0);
    chk("acc", 8'h07, {4'h0, acc});
    run(exec_pkg::op_bank_to_acc, 4'h0, 4'h0, 1'b0);
    chk("acc", 8'h03, {4'h0, acc});
    run(exec_pkg::op_file_to_acc, 4'h0, 4'h0, 1'b0);
    run(exec_pkg::op_stackptr_to_acc, 4'h0, 4'h0, 1'b0);
    chk("acc", 8'h05, {4'h0, acc});
    $display("test partial loads done");
  endtask

  task automatic t_pair;
    run(exec_pkg::op_load_file_row_imm, 4'h1, 4'h2, 1'b0);
    run(exec_pkg::op_load_file_row_imm, 4'h3, 4'h4, 1'b1);
    chk("x", 8'h01, {4'h0, file_x});
    run(exec_pkg::op_load_file_row_imm, 4'h5, 4'h6, 1'b1);
    chk("y", 8'h02, {4'h0, row_y});
    run(exec_pkg::op_nop, 4'h0, 4'h0, 1'b0);
    run(exec_pkg::op_load_file_row_imm, 4'h7, 4'h8, 1'b0);
    chk("x", 8'h07, {4'h0, file_x});
    $display("test paired loads done");
  endtask

  task automatic t_step;
    run(exec_pkg::op_nop, 4'h0, 4'h0, 1'b0);
    run(exec_pkg::op_load_file_row_imm, 4'h2, 4'he, 1'b0);
    run(exec_pkg::op_increment_row_skip, 4'h0, 4'h0, 1'b0);
    chk("y", 8'h0f, {4'h0, row_y});
    run(exec_pkg::op_file_to_acc, 4'h0, 4'h0, 1'b0);
    run(exec_pkg::op_increment_row_skip, 4'h0, 4'h0, 1'b0);
    chk("y", 8'h00, {4'h0, row_y});
    run(exec_pkg::op_acc_to_row, 4'h0, 4'h0, 1'b1);
    chk("y", 8'h00, {4'h0, row_y});
    run(exec_pkg::op_decrement_row_skip, 4'h0, 4'h0, 1'b0);
    chk("y", 8'h0f, {4'h0, row_y});
    run(exec_pkg::op_increment_row_skip, 4'h0, 4'h0, 1'b1);
    chk("y", 8'h0f, {4'h0, row_y});
    run(exec_pkg::op_decrement_row_skip, 4'h0, 4'h0, 1'b0);
    run(exec_pkg::op_file_to_acc, 4'h0, 4'h0, 1'b0);
    $display("test row stepping done");
  endtask

  // Memory is not reset, so every place is written before it is read
  task automatic t_ram;
    run(exec_pkg::op_load_bank_imm, 4'h0, 4'h1, 1'b0);
    run(exec_pkg::op_load_file_row_imm, 4'h3, 4'h4, 1'b0);
    run(exec_pkg::op_file_to_acc, 4'h0, 4'h0, 1'b0);
    run(exec_pkg::op_store_acc_to_ram, 4'h0, 4'h6, 1'b0);
    chk("x", 8'h05, {4'h0, file_x});
    run(exec_pkg::op_bank_to_acc, 4'h0, 4'h0, 1'b0);
    run(exec_pkg::op_store_acc_to_ram, 4'h0, 4'h0, 1'b0);
    run(exec_pkg::op_load_acc_from_ram, 4'h0, 4'h6, 1'b0);
    chk("acc", 8'h01, {4'h0, acc});
    chk("x", 8'h03, {4'h0, file_x});
    run(exec_pkg::op_swap_acc_ram, 4'h0, 4'h0, 1'b0);
    chk("acc", 8'h03, {4'h0, acc});
    run(exec_pkg::op_load_acc_from_ram, 4'h0, 4'h0, 1'b0);
    chk("acc", 8'h01, {4'h0, acc});
    run(exec_pkg::op_row_to_acc, 4'h0, 4'h0, 1'b0);
    run(exec_pkg::op_swap_acc_ram_dec, 4'h0, 4'h0, 1'b0);
    chk("acc", 8'h01, {4'h0, acc});
    chk("y", 8'h03, {4'h0, row_y});
    run(exec_pkg::op_load_file_row_imm, 4'h3, 4'h0, 1'b0);
    run(exec_pkg::op_store_acc_to_ram, 4'h0, 4'h0, 1'b0);
    run(exec_pkg::op_row_to_acc, 4'h0, 4'h0, 1'b0);
    run(exec_pkg::op_swap_acc_ram_dec, 4'h0, 4'h5, 1'b0);
    chk("acc", 8'h01, {4'h0, acc});
    chk("x", 8'h06, {4'h0, file_x});
    chk("y", 8'h0f, {4'h0, row_y});
    run(exec_pkg::op_file_to_acc, 4'h0, 4'h0, 1'b1);
    chk("acc", 8'h01, {4'h0, acc});
    run(exec_pkg::op_store_acc_to_ram, 4'h0, 4'h0, 1'b0);
    run(exec_pkg::op_row_to_acc, 4'h0, 4'h0, 1'b0);
    run(exec_pkg::op_swap_acc_ram_inc, 4'h0, 4'h0, 1'b0);
    chk("acc", 8'h01, {4'h0, acc});
    chk("y", 8'h00, {4'h0, row_y});
    run(exec_pkg::op_file_to_acc, 4'h0, 4'h0, 1'b1);
    chk("acc", 8'h01, {4'h0, acc});
    $display("test memory ops done");
  endtask

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    rst = 1'b1;
    instr_valid = 1'b0;
    instr_op = exec_pkg::op_nop;
    instr_imm_hi = 4'h0;
    instr_imm_lo = 4'h0;
    stack_pointer = 3'h5;
    error_cnt = 0;
    samples_checked = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_xfer();
    t_part();
    t_pair();
    t_step();
    t_ram();
    final_report();
  end
endmodule
